// ==== osc_env_model.sv ====
// Model of the crystal, the lock detector and the clock detector outside
// the reset sequencer. Assumes the bench starts the crystal with run and
// decides with clk_ok whether the clock detector sees a clock.
`timescale 1ns/10ps
module osc_env_model (
  // Clock and controls from the bench.
  input wire logic clk,
  input wire logic run,
  input wire logic clk_ok,
  // Levels towards the sequencer.
  output logic osc_tick,
  output logic pll_lock,
  output logic clock_present
);
  logic [3:0] ticks_q = 4'h0;
  logic half_q = 1'b0;
  initial osc_tick = 1'b0;
  // A cold crystal stands still, so no edge reaches the counter before run.
  always @(posedge clk) begin
    if (!run) begin
      half_q <= 1'b0;
      osc_tick <= 1'b0;
      ticks_q <= 4'h0;
    end else begin
      half_q <= ~half_q;
      if (half_q) begin
        osc_tick <= ~osc_tick;
      end
      if (half_q && !osc_tick && ticks_q != 4'hF) begin
        ticks_q <= ticks_q + 4'h1;
      end
    end
  end
  // Lock comes some oscillator periods after the crystal starts.
  assign pll_lock = (ticks_q == 4'hF);
  assign clock_present = clk_ok;
endmodule : osc_env_model

// ==== osc_if.sv ====
// Interface between the sequencer and its oscillator start-up counter.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface osc_if;
  logic start;
  logic osc_tick;
  logic pll_need;
  logic pll_lock;
  logic ready;
  modport seq (output start, output osc_tick, output pll_need,
               output pll_lock, input ready);
  modport osc_startup_counter (input start, input osc_tick, input pll_need,
               input pll_lock, output ready);
endinterface : osc_if

// ==== osc_startup.sv ====
// Oscillator start-up counter with optional PLL lock wait.
// Assumes start is a level held while a new start-up is wanted.
`timescale 1ns/10ps
module osc_startup
  import rst_seq_pkg::*;
#(
  parameter int COUNT = OST_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  osc_if.osc_startup_counter o
);
  logic [OST_W-1:0] cnt_q;
  logic done_q;
  logic ready_q;

  // A 10-bit count of oscillator periods gates the clock. (see RQ16)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (o.start) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q && o.osc_tick) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == OST_W'(COUNT - 1)) done_q <= 1'b1;
    end
  end

  // Ready waits for PLL lock as well as the start-up count when pll_need is set; the two can overlap. (see RQ17)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ready_q <= 1'b0;
    else ready_q <= done_q && (!o.pll_need || o.pll_lock) && !o.start;
  end
  assign o.ready = ready_q;

  ost_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(done_q) |-> $past(cnt_q) == OST_W'(COUNT - 1)) // see RQ16
    else $error("start-up count ended early");
endmodule : osc_startup

// ==== reset_flag_sequencer.sv ====
// Reset cause recording and master reset release sequencing.
// Assumes event inputs are one-cycle pulses from logic on CLK, while
// reset-source pins and analog detector levels are asynchronous.
// Operation
// (RQ1) Supply flags are set by hardware only; software may only clear.
// (RQ2) Supply register bits 15..5 read zero; bit 4 reserved zero.
// (RQ3) Main-supply brown-out sets supply flag bit 3.
// (RQ4) Main-supply power-on sets bit 2; core power-on sets cause bit 0.
// (RQ5) Missing or low battery, or first power-up, sets bit 1.
// (RQ6) Leaving power-on reset with battery present sets bit 0.
// (RQ7) Trap, illegal-op, mismatch, pin, soft flags: own event; cleared by POR.
// (RQ8) Watchdog flag set on timeout; cleared by wdt-clear, power-save, POR.
// (RQ9) Power-save 0 sets sleep (plus deep sleep if enabled), 1 sets idle.
// (RQ10) Software may set or clear cause flags without causing reset.
// (RQ11) Power-on clears cause register except brown-out and POR, set.
// (RQ12) Any active reset source asserts the master system reset.
// (RQ13) Only cause and oscillator state vary by reset type.
// (RQ14) POR release after power-on, regulator and internal delays.
// (RQ15) Pin, watchdog, soft, trap resets hold only internal reset time.
// (RQ16) Crystal start-up counts 1024 oscillator periods.
// (RQ17) Start-up and PLL lock run alongside the reset delay.
// (RQ18) No fetch until a valid clock is released.
// (RQ19) Two-speed start-up runs internal RC until primary is ready.
// (RQ20) Clock source: config bits on POR/BOR, current bits otherwise.
// (RQ21) Clock monitor starts at release; no clock gives RC and trap.
// (RQ22) Enabled brown-out detection causes brown-out reset.
// (RQ23) Reset asserts asynchronously, releases synchronously.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module reset_flag_sequencer
  import rst_seq_pkg::*;
#(
  parameter int TSTARTUP_CYC = 40,
  parameter int OST_LEN = OST_COUNT
) (
  // Clock and power-on reset.
  input wire logic CLK,
  input wire logic RST,
  // Asynchronous reset sources and detector levels.
  input wire logic EXT_RESET_PIN_N,
  input wire logic BROWNOUT_DET,
  input wire logic VDD_POR_DET,
  input wire logic BATTERY_PRESENT,
  input wire logic BATTERY_LOW,
  input wire logic OSC_TICK,
  input wire logic PLL_LOCK,
  input wire logic CLOCK_PRESENT,
  // Same-domain event pulses.
  input wire logic WDT_TIMEOUT,
  input wire logic SOFT_RESET_INSTR,
  input wire logic TRAP_CONFLICT,
  input wire logic ILLEGAL_OP,
  input wire logic CONFIG_MISMATCH,
  input wire logic WATCHDOG_CLEAR_INSTR,
  input wire logic POWER_SAVE_INSTR,
  input wire logic POWER_SAVE_OP,
  // Configuration.
  input wire logic BROWNOUT_ENABLE_CFG,
  input wire logic [2:0] NEW_OSC_CONFIG_BITS,
  // Register port.
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Sequencer outputs.
  output logic MASTER_SYSTEM_RESET,
  output logic CPU_RUN,
  output logic [2:0] CLOCK_SEL,
  output logic CLOCK_FAIL_TRAP
);
  logic [4:0] s1_q, s2_q;
  logic [1:0] tk1_q, tk2_q;
  logic [1:0] cp1_q, cp2_q;
  logic tick_d1_q;
  logic ext_rst, bor_det, vpor_det, bat_pres, bat_low;
  logic clk_ok;
  logic por_q;
  logic bor_ev, short_ev, long_ev;
  logic [15:0] cause_q, supply_q, ctrl_q;
  logic [2:0] cur_osc_q, clk_sel_q;
  seq_e st_q;
  logic [DLY_W-1:0] dly_q;
  logic master_system_reset_q, run_q, trap_q, fail_safe_clock_monitor_on_q, primary_q;
  logic [15:0] rdata_q;
  osc_if oi ();

  // Two-stage synchronisers for the asynchronous levels.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
      tk1_q <= '0;
      tk2_q <= '0;
      cp1_q <= '0;
      cp2_q <= '0;
    end else begin
      s1_q <= {~EXT_RESET_PIN_N, BROWNOUT_DET, VDD_POR_DET, BATTERY_PRESENT,
               BATTERY_LOW};
      s2_q <= s1_q;
      tk1_q <= {OSC_TICK, PLL_LOCK};
      tk2_q <= tk1_q;
      cp1_q <= {CLOCK_PRESENT, 1'b0};
      cp2_q <= cp1_q;
    end
  end
  assign {ext_rst, bor_det, vpor_det, bat_pres, bat_low} = s2_q;
  assign clk_ok = cp2_q[1];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) tick_d1_q <= 1'b0;
    else tick_d1_q <= tk2_q[1];
  end

  // Brown-out only counts when enabled. (see RQ22)
  assign bor_ev = bor_det && BROWNOUT_ENABLE_CFG;
  assign long_ev = bor_ev || vpor_det;
  assign short_ev = ext_rst || WDT_TIMEOUT || SOFT_RESET_INSTR ||
                    TRAP_CONFLICT || ILLEGAL_OP || CONFIG_MISMATCH;

  // Marks the first cycles after power-on so the exit flags can be caught.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) por_q <= 1'b1;
    else if (st_q == ST_RUN) por_q <= 1'b0;
  end

  // Cause flags: events set, software writes any value, POR presets.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cause_q <= CAUSE_POR_VAL; // see RQ11
    end else begin
      logic [15:0] c;
      c = cause_q;
      if (WR && ADDR == ADDR_CAUSE)
        c = wr_mask(c, WDATA, CAUSE_MASK); // see RQ10
      if (WATCHDOG_CLEAR_INSTR || POWER_SAVE_INSTR)
        c[B_WDT] = 1'b0; // see RQ8
      if (TRAP_CONFLICT) c[B_TRAP] = 1'b1; // see RQ7
      if (ILLEGAL_OP) c[B_ILL] = 1'b1;
      if (CONFIG_MISMATCH) c[B_CM] = 1'b1;
      if (ext_rst) c[B_EXT] = 1'b1;
      if (SOFT_RESET_INSTR) c[B_SWR] = 1'b1;
      if (WDT_TIMEOUT) c[B_WDT] = 1'b1; // see RQ8
      if (POWER_SAVE_INSTR && !POWER_SAVE_OP) begin
        c[B_SLP] = 1'b1; // see RQ9
        if (ctrl_q[B_DEEP_SLEEP_ENABLE]) c[B_DSLP] = 1'b1;
      end
      if (POWER_SAVE_INSTR && POWER_SAVE_OP) c[B_IDL] = 1'b1;
      if (bor_ev) c[B_BOR] = 1'b1;
      cause_q <= c;
    end
  end

  // Supply flags: hardware sets, software writes of one clear. (see RQ1)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      supply_q <= '0;
      supply_q[B_VPOR] <= 1'b1; // see RQ4
      supply_q[B_BATTERY_POWERON_FLAG] <= 1'b1; // see RQ5
    end else begin
      logic [15:0] s;
      s = supply_q;
      if (WR && ADDR == ADDR_SUPPLY)
        s = s & ~(WDATA & SUPPLY_MASK); // see RQ1
      if (bor_ev) s[B_VBOR] = 1'b1; // see RQ3
      if (vpor_det) s[B_VPOR] = 1'b1; // see RQ4
      if (bat_low || !bat_pres) s[B_BATTERY_POWERON_FLAG] = 1'b1; // see RQ5
      if (por_q && st_q == ST_WAIT && dly_q == '0 && bat_pres)
        s[B_VBAT] = 1'b1; // see RQ6
      supply_q <= s & SUPPLY_MASK; // see RQ2
    end
  end

  // Control register resets only on power-on. (see RQ13)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ctrl_q <= '0;
    else if (WR && ADDR == ADDR_CTRL) ctrl_q <= WDATA & CTRL_MASK;
  end

  // Release sequence: assert at once, count, release on the clock.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_HOLD; // see RQ23
      dly_q <= DLY_W'(POWERON_DELAY_CYC + TSTARTUP_CYC + TRST_CYC); // see RQ14
      master_system_reset_q <= 1'b1;
    end else if (long_ev) begin
      st_q <= ST_HOLD; // see RQ12
      dly_q <= DLY_W'(TSTARTUP_CYC + TRST_CYC); // see RQ14
      master_system_reset_q <= 1'b1;
    end else if (short_ev) begin
      st_q <= ST_HOLD; // see RQ15
      dly_q <= DLY_W'(TRST_CYC);
      master_system_reset_q <= 1'b1;
    end else begin
      unique case (st_q)
        ST_HOLD: st_q <= ST_WAIT;
        ST_WAIT: begin
          if (dly_q == '0) begin
            st_q <= ST_RUN;
            master_system_reset_q <= 1'b0; // see RQ23
          end else begin
            dly_q <= dly_q - 1'b1;
          end
        end
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_HOLD;
      endcase
    end
  end

  // Oscillator counting restarts with every reset, long or short. (see RQ17)
  assign oi.start = (st_q == ST_HOLD) && (master_system_reset_q || long_ev);
  assign oi.osc_tick = tk2_q[1] && !tick_d1_q;
  assign oi.pll_need = ctrl_q[B_PLL];
  assign oi.pll_lock = tk2_q[0];

  osc_startup #(.COUNT(OST_LEN)) u_ost (
    .clk(CLK),
    .rst(RST),
    .o(oi.seq)
  );

  // Clock choice per reset type. (see RQ20)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cur_osc_q <= OSC_FRC;
    end else if (long_ev || !ctrl_q[B_CSWEN]) begin
      cur_osc_q <= NEW_OSC_CONFIG_BITS;
    end
  end

  // The primary oscillator is trusted again only after a fresh start-up
  // count, whether or not clock switching is enabled. (see RQ19)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) primary_q <= 1'b0;
    else if (oi.start) primary_q <= 1'b0;
    else if (oi.ready) primary_q <= 1'b1; // see RQ19
  end

  // Two-speed start-up, then fail-safe fallback. (see RQ19)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) clk_sel_q <= OSC_FRC;
    else if (trap_q) clk_sel_q <= OSC_FRC; // see RQ21
    else if (ctrl_q[B_TWOSPD] && !primary_q) clk_sel_q <= OSC_FRC;
    else clk_sel_q <= cur_osc_q;
  end

  // Monitor starts checking after release. (see RQ21)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fail_safe_clock_monitor_on_q <= 1'b0;
      trap_q <= 1'b0;
    end else begin
      fail_safe_clock_monitor_on_q <= ctrl_q[B_FSCMEN] && !master_system_reset_q;
      if (master_system_reset_q) trap_q <= 1'b0;
      else if (fail_safe_clock_monitor_on_q && !clk_ok) trap_q <= 1'b1;
    end
  end

  // Fetch only after reset release and a valid clock. (see RQ18)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) run_q <= 1'b0;
    else run_q <= !master_system_reset_q && (oi.ready || !ctrl_q[B_XTAL] ||
                                ctrl_q[B_TWOSPD] || trap_q);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) rdata_q <= '0;
    else if (RD) begin
      unique case (ADDR)
        ADDR_CAUSE: rdata_q <= cause_q & CAUSE_MASK;
        ADDR_SUPPLY: rdata_q <= supply_q & SUPPLY_MASK; // see RQ2
        ADDR_CTRL: rdata_q <= ctrl_q;
        ADDR_STAT: rdata_q <= {9'h000, clk_sel_q, trap_q, oi.ready,
                               run_q, master_system_reset_q};
        default: rdata_q <= '0;
      endcase
    end else rdata_q <= '0;
  end

  assign RDATA = rdata_q;
  assign MASTER_SYSTEM_RESET = master_system_reset_q;
  assign CPU_RUN = run_q;
  assign CLOCK_SEL = clk_sel_q;
  assign CLOCK_FAIL_TRAP = trap_q;

  supply_sw_a: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == ADDR_SUPPLY && !bor_ev) |=> !$rose(supply_q[B_VBOR]))
    else $error("software set a supply flag"); // see RQ1
  supply_hi_a: assert property (@(posedge CLK) disable iff (RST)
    supply_q[15:4] == '0) else $error("supply high bits set"); // see RQ2
  vbor_set_a: assert property (@(posedge CLK) disable iff (RST)
    bor_ev |=> supply_q[B_VBOR] && cause_q[B_BOR])
    else $error("brown-out flag not set"); // see RQ3
  trap_flag_a: assert property (@(posedge CLK) disable iff (RST)
    TRAP_CONFLICT |=> cause_q[B_TRAP]) else $error("trap flag"); // see RQ7
  wdt_flag_a: assert property (@(posedge CLK) disable iff (RST)
    (WATCHDOG_CLEAR_INSTR && !WDT_TIMEOUT && !WR) |=> !cause_q[B_WDT])
    else $error("watchdog flag not cleared"); // see RQ8
  idle_flag_a: assert property (@(posedge CLK) disable iff (RST)
    (POWER_SAVE_INSTR && POWER_SAVE_OP) |=> cause_q[B_IDL])
    else $error("idle flag not set"); // see RQ9
  any_rst_a: assert property (@(posedge CLK) disable iff (RST)
    (long_ev || short_ev) |=> MASTER_SYSTEM_RESET)
    else $error("reset not asserted"); // see RQ12
  short_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (short_ev && !long_ev) ##1 (!long_ev && !short_ev) [*2]
    |-> MASTER_SYSTEM_RESET) else $error("short hold too brief"); // see RQ15
  run_gate_a: assert property (@(posedge CLK) disable iff (RST)
    CPU_RUN |-> $past(!master_system_reset_q)) else $error("run during reset"); // see RQ18
  fail_trap_a: assert property (@(posedge CLK) disable iff (RST)
    trap_q |=> CLOCK_SEL == OSC_FRC) else $error("no RC fallback"); // see RQ21

  release_c: cover property (@(posedge CLK) $fell(MASTER_SYSTEM_RESET));
  bor_c: cover property (@(posedge CLK) bor_ev);
  trap_c: cover property (@(posedge CLK) $rose(CLOCK_FAIL_TRAP));
  run_c: cover property (@(posedge CLK) $rose(CPU_RUN));
endmodule : reset_flag_sequencer

// ==== reset_flag_sequencer_tb.sv ====
// Self-checking bench for the reset sequencer: register tasks and reset
// scenarios. Assumes the oscillator model drives the clock-related inputs.
`timescale 1ns/10ps
module reset_flag_sequencer_tb;
  import rst_seq_pkg::*;
  localparam int TS = 20;
  localparam int OL = 4;
  localparam int SHORT = TRST_CYC + 2;
  localparam int LONG = TS + TRST_CYC + 2;
  logic CLK = 0, RST = 1, EXT_RESET_PIN_N = 1, BROWNOUT_DET = 0;
  logic VDD_POR_DET = 0, BATTERY_PRESENT = 1, BATTERY_LOW = 0;
  logic POWER_SAVE_OP = 0, BROWNOUT_ENABLE_CFG = 1, WR = 0, RD = 0;
  logic osc_run = 0, clk_ok = 1;
  logic [6:0] evt = '0;
  logic [2:0] NEW_OSC_CONFIG_BITS = 3'h5;
  logic [3:0] ADDR = '0;
  logic [15:0] WDATA = '0;
  logic [15:0] RDATA;
  logic MASTER_SYSTEM_RESET, CPU_RUN, CLOCK_FAIL_TRAP;
  logic OSC_TICK, PLL_LOCK, CLOCK_PRESENT;
  logic [2:0] CLOCK_SEL;
  int error_cnt = 0, tests_run = 0, n;
  int bits[5] = '{B_WDT, B_SWR, B_TRAP, B_ILL, B_CM};
  always #25 CLK = ~CLK;
  osc_env_model env (.clk(CLK), .run(osc_run), .clk_ok(clk_ok),
    .osc_tick(OSC_TICK), .pll_lock(PLL_LOCK), .clock_present(CLOCK_PRESENT));
  reset_flag_sequencer #(.TSTARTUP_CYC(TS), .OST_LEN(OL)) dut (
    .CLK(CLK), .RST(RST), .EXT_RESET_PIN_N(EXT_RESET_PIN_N),
    .BROWNOUT_DET(BROWNOUT_DET), .VDD_POR_DET(VDD_POR_DET),
    .BATTERY_PRESENT(BATTERY_PRESENT), .BATTERY_LOW(BATTERY_LOW),
    .OSC_TICK(OSC_TICK), .PLL_LOCK(PLL_LOCK), .CLOCK_PRESENT(CLOCK_PRESENT),
    .WDT_TIMEOUT(evt[0]), .SOFT_RESET_INSTR(evt[1]), .TRAP_CONFLICT(evt[2]),
    .ILLEGAL_OP(evt[3]), .CONFIG_MISMATCH(evt[4]),
    .WATCHDOG_CLEAR_INSTR(evt[5]), .POWER_SAVE_INSTR(evt[6]),
    .POWER_SAVE_OP(POWER_SAVE_OP), .BROWNOUT_ENABLE_CFG(BROWNOUT_ENABLE_CFG),
    .NEW_OSC_CONFIG_BITS(NEW_OSC_CONFIG_BITS), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA),
    .MASTER_SYSTEM_RESET(MASTER_SYSTEM_RESET), .CPU_RUN(CPU_RUN),
    .CLOCK_SEL(CLOCK_SEL), .CLOCK_FAIL_TRAP(CLOCK_FAIL_TRAP));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bit1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask : bit1
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp,
                    input logic [15:0] m = 16'hFFFF);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA & m, exp);
  endtask : rd
  task automatic pulse(input int i);
    @(posedge CLK);
    evt <= 7'h01 << i;
    @(posedge CLK);
    evt <= '0;
    #1;
  endtask : pulse
  // Counts the cycles until the master reset lets go; synced sources
  // may need a few cycles before it rises at all.
  task automatic hold(output int c);
    c = 0;
    while (MASTER_SYSTEM_RESET !== 1'b1 && c < 8) begin
      @(posedge CLK);
      c++;
    end
    while (MASTER_SYSTEM_RESET !== 1'b0) begin
      @(posedge CLK);
      #1;
      c++;
      if (c > 2000) begin
        error_cnt++;
        test_done();
      end
    end
  endtask : hold
  task automatic near(input int c, input int exp);
    bit1(c >= exp - 6 && c <= exp + 6, 1'b1);
  endtask : near
  task automatic level(input int s, input int cyc);
    @(posedge CLK);
    if (s == 0) EXT_RESET_PIN_N <= 1'b0;
    if (s == 1) BROWNOUT_DET <= 1'b1;
    if (s == 2) VDD_POR_DET <= 1'b1;
    repeat (cyc) @(posedge CLK);
    EXT_RESET_PIN_N <= 1'b1;
    BROWNOUT_DET <= 1'b0;
    VDD_POR_DET <= 1'b0;
  endtask : level
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    hold(n);
    near(n, POWERON_DELAY_CYC + LONG);
    repeat (2) @(posedge CLK);
    #1;
    bit1(CPU_RUN, 1'b1);
    bit1(CLOCK_FAIL_TRAP, 1'b0);
    rd(ADDR_CAUSE, CAUSE_POR_VAL);
    rd(ADDR_SUPPLY, 16'h0007);
    wr(ADDR_SUPPLY, 16'h000F);
    rd(ADDR_SUPPLY, 16'h0000);
    wr(ADDR_CAUSE, CAUSE_MASK);
    rd(ADDR_CAUSE, CAUSE_MASK);
    bit1(MASTER_SYSTEM_RESET, 1'b0);
    wr(ADDR_CAUSE, 16'h0000);
    rd(ADDR_CAUSE, 16'h0000);
    rd(4'hF, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      bit1(MASTER_SYSTEM_RESET, 1'b1);
      hold(n);
      near(n, SHORT);
      rd(ADDR_CAUSE, 16'h0001 << bits[i]);
      wr(ADDR_CAUSE, 16'h0000);
    end
    level(0, 3);
    hold(n);
    near(n, SHORT);
    rd(ADDR_CAUSE, 16'h0001 << B_EXT);
    pulse(0);
    hold(n);
    pulse(5);
    rd(ADDR_CAUSE, 16'h0001 << B_EXT);
    pulse(0);
    hold(n);
    POWER_SAVE_OP <= 1'b1;
    pulse(6);
    rd(ADDR_CAUSE, 16'h0084);
    wr(ADDR_CAUSE, 16'h0000);
    POWER_SAVE_OP <= 1'b0;
    pulse(6);
    rd(ADDR_CAUSE, 16'h0008);
    wr(ADDR_CTRL, 16'h0001 << B_DEEP_SLEEP_ENABLE);
    pulse(6);
    rd(ADDR_CAUSE, 16'h0408);
    wr(ADDR_CAUSE, 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    BROWNOUT_ENABLE_CFG <= 1'b0;
    level(1, 4);
    repeat (6) @(posedge CLK);
    #1;
    bit1(MASTER_SYSTEM_RESET, 1'b0);
    rd(ADDR_SUPPLY, 16'h0000, 16'h0008);
    BROWNOUT_ENABLE_CFG <= 1'b1;
    level(1, 4);
    hold(n);
    near(n, LONG);
    rd(ADDR_SUPPLY, 16'h0008, 16'h000E);
    rd(ADDR_CAUSE, 16'h0002);
    chk({13'h0, CLOCK_SEL}, {13'h0, NEW_OSC_CONFIG_BITS});
    level(2, 4);
    hold(n);
    rd(ADDR_SUPPLY, 16'h0004, 16'h0004);
    wr(ADDR_SUPPLY, 16'h000F);
    BATTERY_LOW <= 1'b1;
    repeat (4) @(posedge CLK);
    BATTERY_LOW <= 1'b0;
    rd(ADDR_SUPPLY, 16'h0002, 16'h0002);
    wr(ADDR_CTRL, 16'h0001 << B_XTAL);
    pulse(1);
    hold(n);
    repeat (20) @(posedge CLK);
    #1;
    bit1(CPU_RUN, 1'b0);
    osc_run <= 1'b1;
    n = 0;
    while (CPU_RUN !== 1'b1 && n < 200) begin
      @(posedge CLK);
      #1;
      n++;
    end
    bit1(n >= 4 * (OL - 1) && n < 200, 1'b1);
    osc_run <= 1'b0;
    wr(ADDR_CTRL, (16'h0001 << B_XTAL) | (16'h0001 << B_TWOSPD));
    pulse(1);
    hold(n);
    repeat (4) @(posedge CLK);
    #1;
    chk({13'h0, CLOCK_SEL}, {13'h0, OSC_FRC});
    bit1(CPU_RUN, 1'b1);
    osc_run <= 1'b1;
    n = 0;
    while (CLOCK_SEL !== NEW_OSC_CONFIG_BITS && n < 200) begin
      @(posedge CLK);
      #1;
      n++;
    end
    bit1(n < 200, 1'b1);
    wr(ADDR_CTRL, 16'h0001 << B_FSCMEN);
    clk_ok <= 1'b0;
    pulse(1);
    hold(n);
    repeat (20) @(posedge CLK);
    #1;
    bit1(CLOCK_FAIL_TRAP, 1'b1);
    chk({13'h0, CLOCK_SEL}, {13'h0, OSC_FRC});
    test_done();
  end
endmodule : reset_flag_sequencer_tb

// ==== rst_seq_pkg.sv ====
// Package for the reset sequencer: register map, field positions, timing.
// Assumes a 20 MHz system clock and a 16-bit register port.
package rst_seq_pkg;
  localparam int CLK_MHZ = 20;
  localparam int POWERON_DELAY_US = 10;
  localparam int TRST_US = 2;
  localparam int POWERON_DELAY_CYC = (POWERON_DELAY_US * CLK_MHZ < 1) ? 1 : POWERON_DELAY_US * CLK_MHZ;
  localparam int TRST_CYC = (TRST_US * CLK_MHZ < 1) ? 1 : TRST_US * CLK_MHZ;
  localparam int OST_COUNT = 1024;
  localparam int OST_W = 10;
  localparam int DLY_W = 12;
  // Register word addresses.
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_SUPPLY = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  // Cause register fields.
  localparam int B_TRAP = 15;
  localparam int B_ILL = 14;
  localparam int B_DSLP = 10;
  localparam int B_CM = 9;
  localparam int B_EXT = 7;
  localparam int B_SWR = 6;
  localparam int B_WDT = 4;
  localparam int B_SLP = 3;
  localparam int B_IDL = 2;
  localparam int B_BOR = 1;
  localparam int B_POR = 0;
  localparam logic [15:0] CAUSE_MASK = 16'hC6DF;
  localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;
  // Supply register fields.
  localparam int B_VBOR = 3;
  localparam int B_VPOR = 2;
  localparam int B_BATTERY_POWERON_FLAG = 1;
  localparam int B_VBAT = 0;
  localparam logic [15:0] SUPPLY_MASK = 16'h000F;
  // Control register fields.
  localparam int B_DEEP_SLEEP_ENABLE = 0;
  localparam int B_CSWEN = 1;
  localparam int B_TWOSPD = 2;
  localparam int B_FSCMEN = 3;
  localparam int B_PLL = 4;
  localparam int B_XTAL = 5;
  localparam logic [15:0] CTRL_MASK = 16'h003F;
  localparam logic [2:0] OSC_FRC = 3'h0;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11
  } seq_e;
  function automatic logic [15:0] wr_mask(logic [15:0] old_v,
                                           logic [15:0] new_v,
                                           logic [15:0] m);
    wr_mask = (old_v & ~m) | (new_v & m);
  endfunction : wr_mask
endpackage : rst_seq_pkg
